// ---- design/ttm_pkg.sv ----
// package for the turbine trip and mode logic: register map, field positions,
// reset values and timing constants shared by the design and its bench.
// assumes a 40 MHz system clock and a 32-bit APB register bus.
package ttm_pkg;
  localparam int unsigned CLK_HZ              = 40_000_000;
  // power-up blanking of trip input one, in milliseconds
  localparam int unsigned BLANK_TIME_MS       = 1500;
  localparam int unsigned BLANK_CYCLES        = CLK_HZ / 1000 * BLANK_TIME_MS;
  // speed measurement gate, in milliseconds
  localparam int unsigned GATE_TIME_MS        = 1000;
  localparam int unsigned GATE_CYCLES         = CLK_HZ / 1000 * GATE_TIME_MS;
  localparam int unsigned SEC_PER_MIN         = 60;

  // register byte offsets
  localparam logic [7:0] REG_CONTROL  = 8'h00;
  localparam logic [7:0] REG_TRIP_RPM = 8'h04;
  localparam logic [7:0] REG_TEETH    = 8'h08;
  localparam logic [7:0] REG_READOUT  = 8'h0c;
  localparam logic [7:0] REG_SCALE    = 8'h10;
  localparam logic [7:0] REG_STATUS   = 8'h14;
  localparam logic [7:0] REG_SPEED    = 8'h18;
  localparam logic [7:0] REG_COMMAND  = 8'h1c;

  // control register bit positions
  localparam int CTL_OVSP_EN       = 0;
  localparam int CTL_OVSP_FORCE    = 1;
  localparam int CTL_OVSP_MANONLY  = 2;
  localparam int CTL_T1_EN         = 3;
  localparam int CTL_T1_NC         = 4;
  localparam int CTL_BLANK         = 5;
  localparam int CTL_T2_EN         = 6;
  localparam int CTL_T2_NC         = 7;
  localparam int CTL_T2_MANONLY    = 8;
  localparam int CTL_T3_EN         = 9;
  localparam int CTL_T3_NC         = 10;
  localparam int CTL_T3_MANONLY    = 11;
  localparam int CTL_SEL_AUTO      = 12;
  localparam int CTL_WIDTH         = 13;
  // trip input enables and blanking true, all else false
  localparam logic [12:0] CONTROL_RST = 13'h0268;
  localparam logic [15:0] TRIP_RPM_RST = 16'h2710;
  localparam logic [8:0]  TEETH_RST    = 9'h03c;
  localparam logic [2:0]  SRC_RST      = 3'h1;
  localparam logic [2:0]  SRC_SPEED    = 3'h4;
  localparam logic signed [15:0] LOW_SCALE_RST  = 16'sh0000;
  localparam logic signed [15:0] HIGH_SCALE_RST = 16'sh0064;
  // readout in micro-amps
  localparam int unsigned UA_LOW  = 4000;
  localparam int unsigned UA_SPAN = 16000;

  // command register bits
  localparam int CMD_ENTER = 0;
  localparam int CMD_ESC   = 1;
  localparam int CMD_SAVE  = 2;

  typedef enum logic [1:0] {
    TTM_RUN,
    TTM_CONFIRM,
    TTM_CONFIG
  } ttm_cfg_e;
endpackage

// ---- design/ttm_trip_logic.sv ----
// trip and mode logic of a valve actuator position controller, as an apb slave.
// assumes contact and pulse inputs are already debounced and synchronous to clk_in.
// Summary of operation
// - overspeed acts only when the overspeed enable bit is set
// - force-manual: overspeed on either pickup forces manual mode and trips
// - manual-only overspeed: trip only in manual, nothing in auto unless force-manual is also set
// - speed compared against programmable trip rpm
// - each pickup has its own tooth count
// - trip input one honoured only when enabled
// - trip inputs two and three honoured only when enabled
// - normally-closed polarity makes an open contact the trip condition
// - blanking ignores trip input one for 1.5 s after governor power-up
// - trip input two manual-only setting ignores it in auto
// - trip input three manual-only setting ignores it in auto
// - selector polarity bit decides whether closed contact requests auto
// - auto passes governor demand; manual drives actuator locally
// - two confirmations enter configuration and shut outputs down
// - leaving configuration saves set points, flags reboot, restarts
// - save accepted at any time, even during configuration
// - speed readout scales low speed to 4 mA, high to 20 mA
// - enabled trip input condition trips turbine, sets its status
// - enabled overspeed trips turbine, sets overspeed status
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
module ttm_trip_logic #(
  parameter int unsigned BLANK_CYC = ttm_pkg::BLANK_CYCLES,
  parameter int unsigned GATE_CYC  = ttm_pkg::GATE_CYCLES
) (
  input  wire logic        clk_in,          // 40 mhz system clock
  input  wire logic        arst_n_in,       // async reset, active low
  input  wire logic        psel_in,         // apb select
  input  wire logic        penable_in,      // apb enable
  input  wire logic        pwrite_in,       // apb write
  input  wire logic [7:0]  paddr_in,        // apb byte address
  input  wire logic [31:0] pwdata_in,       // apb write data
  output logic      [31:0] prdata_out,      // apb read data
  output logic             pready_out,      // apb ready
  output logic             pslverr_out,     // apb error, unmapped address
  input  wire logic        pickup_one_in,   // speed pickup one pulses
  input  wire logic        pickup_two_in,   // speed pickup two pulses
  input  wire logic        trip_one_in,     // trip contact one, high = closed
  input  wire logic        trip_two_in,     // trip contact two, high = closed
  input  wire logic        trip_three_in,   // trip contact three, high = closed
  input  wire logic        selector_in,     // manual/auto selector, high = closed
  input  wire logic        gov_fail_in,     // governor fault, forces manual
  input  wire logic        gov_powerup_in,  // pulse: governor has powered up
  input  wire logic        nv_done_in,      // nv store has finished a save
  input  wire logic [15:0] gov_demand_in,   // governor actuator demand
  input  wire logic [15:0] local_demand_in, // local manual actuator demand
  output logic      [15:0] act_demand_out,  // actuator demand
  output logic             act_enable_out,  // actuator output enabled
  output logic             shutdown_out,    // turbine shutdown
  output logic             manual_out,      // manual mode
  output logic             nv_save_out,     // pulse: store set points
  output logic             reboot_out,      // pulse: restart after save
  output logic      [15:0] readout_ua_out   // readout one, micro-amps
);
  import ttm_pkg::*;

  logic [CTL_WIDTH-1:0] control_reg;
  logic [15:0]          trip_rpm_reg;
  logic [8:0]           teeth_one_reg, teeth_two_reg;
  logic [2:0]           src_reg;
  logic signed [15:0]   low_scale_reg, high_scale_reg;
  logic [3:0]           trip_stat_reg;
  logic [31:0]          gate_cnt_reg, blank_cnt_reg;
  logic [15:0]          cnt_one_reg, cnt_two_reg, rpm_one_reg, rpm_two_reg;
  logic                 p1_d_reg, p2_d_reg, force_man_reg, save_pend_reg;
  ttm_cfg_e             cfg_reg;

  // rpm from pulses counted in the gate time, per tooth count
  function automatic logic [15:0] to_rpm(input logic [15:0] pulses, input logic [8:0] teeth);
    logic [47:0] num;
    num = 48'(pulses) * 48'(SEC_PER_MIN) * 48'(1000) / 48'(GATE_TIME_MS);
    // a zero tooth count reads as stopped rather than dividing by zero
    to_rpm = (teeth == 9'h000) ? 16'h0000 : 16'(num / 48'(teeth));
  endfunction

  // apb decode; zero-wait answers
  wire access  = psel_in & penable_in;
  wire wr      = access & pwrite_in;
  wire mapped  = (paddr_in[1:0] == 2'b00) && (paddr_in <= REG_COMMAND);
  wire cmd_wr  = wr && (paddr_in == REG_COMMAND);
  wire enter_c = cmd_wr & pwdata_in[CMD_ENTER];
  wire esc_c   = cmd_wr & pwdata_in[CMD_ESC];
  wire save_c  = cmd_wr & pwdata_in[CMD_SAVE];

  // mode: selector polarity, governor fault and overspeed force-manual
  // selector polarity
  wire sel_auto  = control_reg[CTL_SEL_AUTO] ? selector_in : ~selector_in;
  wire manual    = ~sel_auto | gov_fail_in | force_man_reg;

  wire over1     = rpm_one_reg > trip_rpm_reg;
  wire over2     = rpm_two_reg > trip_rpm_reg;
  wire over_any  = over1 | over2;
  wire ovsp_arm  = control_reg[CTL_OVSP_EN] & over_any;
  wire ovsp_trip = ovsp_arm & (control_reg[CTL_OVSP_FORCE] |
                   ~control_reg[CTL_OVSP_MANONLY] | manual);

  wire act1 = control_reg[CTL_T1_NC] ? ~trip_one_in   : trip_one_in;
  wire act2 = control_reg[CTL_T2_NC] ? ~trip_two_in   : trip_two_in;
  wire act3 = control_reg[CTL_T3_NC] ? ~trip_three_in : trip_three_in;
  wire blanked = control_reg[CTL_BLANK] & (blank_cnt_reg != 32'h0);
  wire t1 = control_reg[CTL_T1_EN] & act1 & ~blanked;
  wire t2 = control_reg[CTL_T2_EN] & act2 & (manual | ~control_reg[CTL_T2_MANONLY]);
  wire t3 = control_reg[CTL_T3_EN] & act3 & (manual | ~control_reg[CTL_T3_MANONLY]);
  wire any_trip = t1 | t2 | t3 | ovsp_trip;

  // rising pickup edges; the count saturates so a fast wheel never wraps to a low speed
  wire rise_one = pickup_one_in & ~p1_d_reg & (cnt_one_reg != 16'hffff);
  wire rise_two = pickup_two_in & ~p2_d_reg & (cnt_two_reg != 16'hffff);

  // speed readout scaling, clamped to the 4..20 ma span
  logic signed [47:0] ua_calc;
  logic signed [17:0] span;
  // signed copies of the span limits: a speed below the low scale point stays
  // negative and clamps to 4 ma instead of wrapping through unsigned maths
  localparam logic signed [47:0] UA_LO_S  = 48'(UA_LOW);
  localparam logic signed [47:0] UA_SPN_S = 48'(UA_SPAN);
  localparam logic signed [47:0] UA_HI_S  = 48'(UA_LOW + UA_SPAN);
  always_comb begin
    span    = 18'(high_scale_reg) - 18'(low_scale_reg);
    ua_calc = UA_LO_S;
    if (span > 0) begin
      ua_calc = UA_LO_S + (48'(signed'({2'b00, rpm_one_reg})) - 48'(low_scale_reg))
                * UA_SPN_S / 48'(span);
    end
    if (ua_calc < UA_LO_S) begin
      ua_calc = UA_LO_S;
    end
    if (ua_calc > UA_HI_S) begin
      ua_calc = UA_HI_S;
    end
  end
  wire [15:0] readout_next = (src_reg == SRC_SPEED) ? 16'(ua_calc) : 16'h0000;

  // configuration register writes
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      control_reg    <= CONTROL_RST;
      trip_rpm_reg   <= TRIP_RPM_RST;
      teeth_one_reg  <= TEETH_RST;
      teeth_two_reg  <= TEETH_RST;
      src_reg        <= SRC_RST;
      low_scale_reg  <= LOW_SCALE_RST;
      high_scale_reg <= HIGH_SCALE_RST;
    end else if (wr) begin
      unique case (paddr_in)
        REG_CONTROL:  control_reg  <= pwdata_in[CTL_WIDTH-1:0];
        REG_TRIP_RPM: trip_rpm_reg <= pwdata_in[15:0];
        REG_TEETH: begin
          teeth_one_reg <= pwdata_in[8:0];
          teeth_two_reg <= pwdata_in[24:16];
        end
        REG_READOUT:  src_reg <= pwdata_in[2:0];
        REG_SCALE: begin
          low_scale_reg  <= signed'(pwdata_in[15:0]);
          high_scale_reg <= signed'(pwdata_in[31:16]);
        end
        default: ;
      endcase
    end
  end

  // gated pulse counting; a new gate result replaces the old
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      gate_cnt_reg <= 32'h0;
      cnt_one_reg  <= 16'h0;
      cnt_two_reg  <= 16'h0;
      rpm_one_reg  <= 16'h0;
      rpm_two_reg  <= 16'h0;
      p1_d_reg     <= 1'b0;
      p2_d_reg     <= 1'b0;
    end else begin
      p1_d_reg <= pickup_one_in;
      p2_d_reg <= pickup_two_in;
      if (gate_cnt_reg >= GATE_CYC - 1) begin
        gate_cnt_reg <= 32'h0;
        rpm_one_reg  <= to_rpm(cnt_one_reg, teeth_one_reg);
        rpm_two_reg  <= to_rpm(cnt_two_reg, teeth_two_reg);
        cnt_one_reg  <= 16'h0;
        cnt_two_reg  <= 16'h0;
      end else begin
        gate_cnt_reg <= gate_cnt_reg + 32'h1;
        cnt_one_reg  <= cnt_one_reg + 16'(rise_one);
        cnt_two_reg  <= cnt_two_reg + 16'(rise_two);
      end
    end
  end

  // blanking window restarts on each governor power-up pulse
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      blank_cnt_reg <= 32'h0;
    end else if (gov_powerup_in) begin
      blank_cnt_reg <= BLANK_CYC;
    end else if (blank_cnt_reg != 32'h0) begin
      blank_cnt_reg <= blank_cnt_reg - 32'h1;
    end
  end

  // trip status and latched force-manual; cleared only by a restart
  // so a trip never drops out by itself while the contact chatters
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      trip_stat_reg <= 4'h0;
      force_man_reg <= 1'b0;
    end else begin
      trip_stat_reg <= trip_stat_reg | {ovsp_trip, t3, t2, t1};
      if (ovsp_arm & control_reg[CTL_OVSP_FORCE]) begin
        force_man_reg <= 1'b1;
      end
    end
  end

  // configuration entry sequence and save/reboot
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg_reg       <= TTM_RUN;
      save_pend_reg <= 1'b0;
      nv_save_out   <= 1'b0;
      reboot_out    <= 1'b0;
    end else begin
      nv_save_out <= 1'b0;
      reboot_out  <= 1'b0;
      // a finished save clears pending first, so a new leave request in the same cycle wins
      if (save_pend_reg & nv_done_in) begin
        save_pend_reg <= 1'b0;
        reboot_out    <= 1'b1;
      end
      unique case (cfg_reg)
        TTM_RUN:     if (enter_c) cfg_reg <= TTM_CONFIRM;
        TTM_CONFIRM: begin
          if (enter_c) begin
            cfg_reg <= TTM_CONFIG;
          end else if (esc_c) begin
            cfg_reg <= TTM_RUN;
          end
        end
        TTM_CONFIG: begin
          if (esc_c) begin
            nv_save_out   <= 1'b1;
            save_pend_reg <= 1'b1;
          end
        end
        default: cfg_reg <= TTM_RUN;  // unused code falls back to run
      endcase
      if (save_c) begin
        nv_save_out <= 1'b1;
      end
    end
  end

  // outputs and apb answer; the reboot pulse is the system restart request
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      act_demand_out <= 16'h0;
      act_enable_out <= 1'b0;
      shutdown_out   <= 1'b0;
      manual_out     <= 1'b0;
      readout_ua_out <= 16'h0;
      prdata_out     <= 32'h0;
      pready_out     <= 1'b0;
      pslverr_out    <= 1'b0;
    end else begin
      // auto passes governor demand, manual drives locally
      act_demand_out <= manual ? local_demand_in : gov_demand_in;
      act_enable_out <= (cfg_reg != TTM_CONFIG) & ~any_trip & (trip_stat_reg == 4'h0);
      shutdown_out   <= any_trip | (trip_stat_reg != 4'h0);
      manual_out     <= manual;
      readout_ua_out <= readout_next;
      // answer in the cycle after setup; a refused address rides on the same pulse
      pready_out     <= psel_in & ~penable_in;
      pslverr_out    <= psel_in & ~penable_in & ~mapped;
      // read data follows the address each cycle; only the access cycle's value counts
      unique case (paddr_in)
        REG_CONTROL:  prdata_out <= 32'(control_reg);
        REG_TRIP_RPM: prdata_out <= {16'h0, trip_rpm_reg};
        REG_TEETH:    prdata_out <= {7'h0, teeth_two_reg, 7'h0, teeth_one_reg};
        REG_READOUT:  prdata_out <= {29'h0, src_reg};
        REG_SCALE:    prdata_out <= {high_scale_reg, low_scale_reg};
        REG_STATUS:   prdata_out <= {24'h0, cfg_reg, manual, save_pend_reg, trip_stat_reg};
        REG_SPEED:    prdata_out <= {rpm_two_reg, rpm_one_reg};
        default:      prdata_out <= 32'h0;
      endcase
    end
  end
endmodule

// ---- tb/ttm_field_model.sv ----
// far side model: two toothed-wheel pickups and the nv store.
// assumes the bench spins each wheel; the store answers every save.
`timescale 1ns/1ps
module ttm_field_model (
  input  wire logic clk_in,         // clock
  input  wire logic arst_n_in,      // reset, active low
  input  wire logic run_one_in,     // spin wheel one
  input  wire logic run_two_in,     // spin wheel two
  input  wire logic nv_save_in,     // save request
  output logic      pickup_one_out, // pulses one
  output logic      pickup_two_out, // pulses two
  output logic      nv_done_out     // save finished
);
  logic [1:0] phase_reg;
  logic [4:0] store_reg;
  // a stopped wheel gives no edges; a spinning one a pulse every 4 cycles
  assign pickup_one_out = run_one_in & phase_reg[1];
  assign pickup_two_out = run_two_in & phase_reg[1];
  // the store needs a few cycles, so done never lands with the request
  assign nv_done_out    = store_reg[4];
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      phase_reg <= 2'h0;
      store_reg <= 5'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
      store_reg <= {store_reg[3:0], nv_save_in};
    end
  end
endmodule

// ---- tb/ttm_trip_monitor.sv ----
// checker on the ports of the trip and mode logic.
// assumes one clock domain; bound onto every instance below.
`timescale 1ns/1ps
module ttm_trip_monitor (
  input wire logic        clk_in,          // clock
  input wire logic        arst_n_in,       // reset
  input wire logic        psel_in,         // apb select
  input wire logic        penable_in,      // apb enable
  input wire logic [7:0]  paddr_in,        // apb address
  input wire logic        pready_out,      // apb ready
  input wire logic        pslverr_out,     // apb error
  input wire logic        gov_fail_in,     // governor fault
  input wire logic [15:0] local_demand_in, // local demand
  input wire logic [15:0] act_demand_out,  // actuator demand
  input wire logic        act_enable_out,  // actuator on
  input wire logic        shutdown_out,    // trip latch
  input wire logic        manual_out,      // manual mode
  input wire logic        nv_save_out,     // save pulse
  input wire logic        reboot_out       // reboot pulse
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // offsets past the map or off a word boundary
  wire bad_addr = (paddr_in > 8'h1c) || (paddr_in[1:0] != 2'h0);
  // apb answer timing and refusal
  chk_ready_setup: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no ready after setup");
  chk_ready_access: assert property (pready_out |-> psel_in && penable_in)
    else $error("ready outside access");
  chk_err_unmapped: assert property (psel_in && !penable_in && bad_addr |=> pslverr_out)
    else $error("unmapped not refused");
  chk_trip_sticky: assert property (shutdown_out |=> shutdown_out)
    else $error("trip latch dropped");
  chk_fail_manual: assert property (gov_fail_in |-> ##[1:2] manual_out)
    else $error("fault left auto");
  chk_local_drive: assert property (manual_out && $past(manual_out)
    |-> act_demand_out == $past(local_demand_in))
    else $error("manual demand wrong");
  chk_cfg_off: assert property (reboot_out |-> !act_enable_out)
    else $error("output on in config");
  chk_save_pulse: assert property (nv_save_out |=> !nv_save_out)
    else $error("save not a pulse");
  cov_trip: cover property ($rose(shutdown_out));
  cov_reboot: cover property (reboot_out);
  cov_refuse: cover property (pslverr_out);
endmodule
bind ttm_trip_logic ttm_trip_monitor ttm_trip_monitor_inst (.clk_in, .arst_n_in,
  .psel_in, .penable_in, .paddr_in, .pready_out, .pslverr_out, .gov_fail_in,
  .local_demand_in, .act_demand_out, .act_enable_out, .shutdown_out, .manual_out,
  .nv_save_out, .reboot_out);

// ---- tb/testbench.sv ----
// self-checking bench for the trip and mode logic.
// assumes the field model and the bound checker; short blanking and gate.
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR %0t got %0h want %0h", $time, (a), (b)); end end
module testbench;
  import ttm_pkg::*;
  localparam int unsigned BLK = 50;
  localparam int unsigned GATE = 100;
  logic clk_in = 0, arst_n_in = 0, psel = 0, pen = 0, pwr = 0, err_q;
  logic sel = 0, fail = 0, gpu = 0, run1 = 0, run2 = 0, pready, perr;
  logic p1, p2, nvs, nvd, act_en, sd, man, reb;
  logic [2:0] trip = 0;
  logic [7:0] paddr = 0;
  logic [15:0] gdem = 0, ldem = 0, adem, ua;
  logic [31:0] pwdata = 0, prdata, rd_q, seed = 32'h1a518c7f;
  logic [31:0] rst_tab [5] = '{{19'h0, CONTROL_RST}, {16'h0, TRIP_RPM_RST},
    {7'h0, TEETH_RST, 7'h0, TEETH_RST}, {29'h0, SRC_RST}, {HIGH_SCALE_RST, LOW_SCALE_RST}};
  int err_count = 0, cmp_count = 0, cyc = 0, nsave = 0, nreb = 0;
  ttm_trip_logic #(.BLANK_CYC(BLK), .GATE_CYC(GATE)) ttm_trip_logic_inst (.clk_in,
    .arst_n_in, .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr),
    .pickup_one_in(p1), .pickup_two_in(p2), .trip_one_in(trip[0]), .trip_two_in(trip[1]),
    .trip_three_in(trip[2]), .selector_in(sel), .gov_fail_in(fail), .gov_powerup_in(gpu),
    .nv_done_in(nvd), .gov_demand_in(gdem), .local_demand_in(ldem), .act_demand_out(adem),
    .act_enable_out(act_en), .shutdown_out(sd), .manual_out(man), .nv_save_out(nvs),
    .reboot_out(reb), .readout_ua_out(ua));
  ttm_field_model ttm_field_model_inst (.clk_in, .arst_n_in, .run_one_in(run1),
    .run_two_in(run2), .nv_save_in(nvs), .pickup_one_out(p1), .pickup_two_out(p2),
    .nv_done_out(nvd));
  always #12.5 clk_in = ~clk_in;
  // cycle ceiling, and pulse counts of save and reboot
  always @(posedge clk_in) begin
    cyc++;
    if (nvs === 1'b1) nsave++;
    if (reb === 1'b1) nreb++;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [2:0] trip_exp(logic [12:0] c, logic [2:0] t, logic m);
    trip_exp[0] = c[CTL_T1_EN] & (t[0] ^ c[CTL_T1_NC]);
    trip_exp[1] = c[CTL_T2_EN] & (t[1] ^ c[CTL_T2_NC]) & (m | ~c[CTL_T2_MANONLY]);
    trip_exp[2] = c[CTL_T3_EN] & (t[2] ^ c[CTL_T3_NC]) & (m | ~c[CTL_T3_MANONLY]);
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) err_count++;
    rd_q = prdata;
    err_q = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic do_reset();
    arst_n_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(posedge clk_in);
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    logic [12:0] c;
    logic [2:0] h;
    logic m, ov, use2;
    int r1, r2;
    do_reset();
    // reset values, then a refused unaligned write and unmapped read
    for (int k = 0; k < 5; k++) begin
      apb(1'b0, 8'(k * 4), 32'h0);
      `CHK(rd_q, rst_tab[k])
    end
    apb(1'b1, 8'h02, 32'h0);
    `CHK(err_q, 1'b1)
    apb(1'b0, 8'h20, 32'h0);
    `CHK({err_q, rd_q}, {1'b1, 32'h0})
    $display("registers done");
    // random contacts, enables raised once inputs settle
    for (int i = 0; i < 24; i++) begin
      c = 13'(rnd()) & 13'h1fd8;
      // contacts left from the last pass would trip the reset-value enables
      {sel, fail, trip} <= 5'h0;
      do_reset();
      apb(1'b1, REG_CONTROL, {19'h0, c & 13'h1db7});
      {sel, fail, trip} <= 5'(rnd());
      gdem <= 16'(rnd());
      ldem <= 16'(rnd());
      repeat (3) @(posedge clk_in);
      apb(1'b1, REG_CONTROL, {19'h0, c});
      repeat (3) @(posedge clk_in);
      m = fail | (sel ^ c[CTL_SEL_AUTO]);
      h = trip_exp(c, trip, m);
      `CHK(man, m)
      `CHK(sd, |h)
      `CHK(adem, m ? ldem : gdem)
      apb(1'b0, REG_STATUS, 32'h0);
      `CHK(rd_q[5:0], {m, 2'h0, h})
    end
    $display("contacts done");
    // powerup pulse blanks input one, wired as the integrator must
    {sel, fail, trip} <= 5'h0;
    do_reset();
    apb(1'b1, REG_CONTROL, 32'h28);
    gpu <= 1'b1;
    @(posedge clk_in);
    gpu <= 1'b0;
    trip <= 3'h1;
    repeat (BLK - 8) @(posedge clk_in);
    `CHK(sd, 1'b0)
    repeat (16) @(posedge clk_in);
    `CHK(sd, 1'b1)
    $display("blanking done");
    // overspeed combos; the last case stays under the limit
    for (int i = 0; i < 17; i++) begin
      ov = i[4] | i[0];
      use2 = i[1] ^ i[3];
      c = {10'h0, i[2], i[1], ov};
      trip <= 3'h0;
      fail <= i[3];
      do_reset();
      apb(1'b1, REG_CONTROL, {19'h0, c});
      apb(1'b1, REG_TRIP_RPM, i[4] ? 32'h4e20 : 32'hc8);
      apb(1'b1, REG_TEETH, 32'h00030005);
      apb(1'b1, REG_READOUT, i[2] ? 32'h4 : 32'h1);
      apb(1'b1, REG_SCALE, 32'h02580000);
      run1 <= ~use2;
      run2 <= use2;
      repeat (3 * GATE) @(posedge clk_in);
      m = i[3] | (ov & i[1] & ~i[4]);
      h[0] = ov & ~i[4] & (i[1] | ~i[2] | i[3]);
      `CHK(sd, h[0])
      `CHK(man, m)
      apb(1'b0, REG_STATUS, 32'h0);
      `CHK(rd_q[3], h[0])
      apb(1'b0, REG_SPEED, 32'h0);
      r1 = use2 ? rd_q[31:16] : rd_q[15:0];
      r2 = use2 ? 500 : 300;
      `CHK(r1 >= r2 - 20 && r1 <= r2 + 20, 1'b1)
      `CHK(use2 ? rd_q[15:0] : rd_q[31:16], 16'h0)
      if (!use2)
        `CHK(i[2] ? (ua >= 16'h2d00 && ua <= 16'h3200) : (ua === 16'h0), 1'b1)
      run1 <= 1'b0;
      run2 <= 1'b0;
    end
    $display("overspeed done");
    // save, two enters, save, leave configuration
    fail <= 1'b0;
    do_reset();
    apb(1'b1, REG_COMMAND, 32'h4);
    repeat (8) @(posedge clk_in);
    `CHK(nsave, 1)
    `CHK(nreb, 0)
    apb(1'b1, REG_COMMAND, 32'h1);
    `CHK(act_en, 1'b1)
    apb(1'b1, REG_COMMAND, 32'h1);
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK({act_en, rd_q[7:6]}, 3'h2)
    apb(1'b1, REG_COMMAND, 32'h4);
    repeat (8) @(posedge clk_in);
    apb(1'b1, REG_COMMAND, 32'h2);
    repeat (8) @(posedge clk_in);
    `CHK(nsave, 3)
    `CHK(nreb, 1)
    $display("configuration done");
    test_done();
  end
endmodule
